// >>> rtl/fdc_seek_cmds.sv
// command interpreter for seek, drive status, interrupt cause, track access and timing setup
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps

// What this block does
// - seek takes target low byte third, upper nibble in fourth byte bits 7-4 if wide
// - seek compares target with present track before each step, sets direction
// - step pulses issued while polling, spaced by loaded step interval value
// - interrupt one step period after last pulse; seek returns no result bytes
// - drive status takes head and drive byte, returns one status byte, no interrupt
// - interrupt cause query with nothing pending is rejected as invalid
// - ready and seek-end interrupts stay pending until first cause byte read
// - status byte zero: bits 7,6 code, bit 5 seek end; 110, 001, 011
// - cause query returns status byte, present track low byte, nibble byte if wide
// - opcode bit 6 picks track read or track write of third byte
// - present track kept per drive; bit 2 picks high or low byte
// - drive code 10 needs four drives or swap, 11 needs four drives
// - track access returns exactly one byte, the byte read or written, no interrupt
// - step, motor delays and transfer mode survive every reset; no interrupt
// - timing byte two: bits 7-4 step interval, bits 3-0 delay-after factor
// - motor-off delay is factor times rate and timer-mode constant; zero means 16
// - timing byte three bit 0 selects DMA (0) or non-DMA (1)
// - delay before processing is factor times constant; zero means 128
// - step interval is sixteen minus value in ms, scaled by data rate
module fdc_seek_cmds
	import fdc_cmd_pkg::*;
#(
	parameter int tick_cyc = TICK_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             step_out,
	output logic             dir_out,
	input  wire logic        track_zero_input,
	input  wire logic        write_protect_input,
	input  wire logic        ready_change,
	output logic             irq_out,
	output logic             motor_hold,
	output logic             non_dma_mode
);
	localparam int PWW = $clog2(STEP_PULSE_CYC + 1);

	if (tick_cyc * 3 <= STEP_PULSE_CYC) begin : g_chk
		$error("fdc_seek_cmds: tick_cyc too short for the step pulse");
	end

	phase_t            ph_q, ph_d;
	seek_t             sk_q, sk_d;
	logic [3:0][7:0]   cmd_q, cmd_d, nc;
	logic [1:0]        ccnt_q, ccnt_d;
	logic [2:0][7:0]   res_q, res_d;
	logic [1:0]        rcnt_q, rcnt_d, ridx_q, ridx_d;
	logic              sense_q, sense_d;
	logic [5:0]        cfg_q, cfg_d;
	logic [3:0][11:0]  pres_q, pres_d;
	logic              int_q, int_d;
	logic [7:0]        st0_q, st0_d;
	logic [1:0]        sk_drv_q, sk_drv_d;
	logic              sk_hd_q, sk_hd_d;
	logic [11:0]       tgt_q, tgt_d;
	logic [3:0]        busy_q, busy_d;
	logic              step_q, step_d, dir_q, dir_d;
	logic [PWW-1:0]    pw_q, pw_d;
	logic [31:0]       prdata_q, prdata_d;
	logic [3:0]        srt_q, srt_d, dap_q, dap_d;
	logic [6:0]        dbp_q, dbp_d;
	logic              dma_q, dma_d;

	logic              wr_acc, rd_acc, take, fin, pop, bad;
	logic              seek_go, seek_end, abn, issue, up, clr_int, set_int;
	logic              res_go, res_sense;
	logic [1:0]        res_n;
	logic [2:0][7:0]   res_v;
	logic [7:0]        op, last_b;
	logic [1:0]        drv, rate;
	logic              hd, ok, wide, tmr;
	logic [11:0]       cur, sptr;
	logic [7:0]        dbp_f;
	logic [4:0]        dap_f, stp_f;
	logic [TICKS_W-1:0] dbp_t, dap_t, stp_t;

	tmr_if t1 ();
	tmr_if t2 ();

	tick_timer #(.tick_cyc(tick_cyc)) u_seek_tmr (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.t       (t1)
	);

	tick_timer #(.tick_cyc(tick_cyc)) u_motor_tmr (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.t       (t2)
	);

	function automatic logic [2:0] cmd_len(input logic [7:0] o, input logic w);
		unique case (o)
			OP_SEEK:                       cmd_len = w ? 3'h4 : 3'h3;
			OP_DSTAT:                      cmd_len = 3'h2;
			OP_SENSE:                      cmd_len = 3'h1;
			OP_TRK_RD, OP_TRK_WR, OP_SPEC: cmd_len = 3'h3;
			default:                       cmd_len = 3'h1;
		endcase
	endfunction : cmd_len

	function automatic logic drv_ok(input logic [1:0] c, input logic four, input logic swap);
		unique case (c)
			2'b10:   drv_ok = four || swap;
			2'b11:   drv_ok = four;
			default: drv_ok = 1'b1;
		endcase
	endfunction : drv_ok

	always_comb begin
		wr_acc = psel && penable && pwrite;
		rd_acc = psel && penable && !pwrite;
		wide   = cfg_q[CFG_WIDE];
		tmr    = cfg_q[CFG_TMR];
		rate   = cfg_q[CFG_RATE +: 2];
		last_b = pwdata[7:0];
		nc     = cmd_q;
		nc[ccnt_q] = last_b;
		op     = nc[0];
		drv    = nc[1][1:0];
		hd     = nc[1][2];
		ok     = drv_ok(drv, cfg_q[CFG_FOUR], cfg_q[CFG_SWAP]);
		take   = wr_acc && (paddr == DATA_OFS) && (ph_q == PH_CMD);
		fin    = take && (({1'b0, ccnt_q} + 3'h1) == cmd_len(op, wide));
		pop    = rd_acc && (paddr == DATA_OFS) && (ph_q == PH_RES);
		bad    = !ok && (op == OP_SEEK || op == OP_DSTAT || op == OP_TRK_RD || op == OP_TRK_WR);
		cur    = pres_q[sk_drv_q];
		up     = tgt_q > cur;
		sptr   = pres_q[st0_q[1:0]];
		// delays in ticks
		dbp_f  = (dbp_q == 7'h00) ? DBP_ZERO : {1'b0, dbp_q};
		dbp_t  = TICKS_W'(dbp_f) * TICKS_W'(tmr ? DBP_UNIT1[rate] : DBP_UNIT0[rate]);
		dap_f  = (dap_q == 4'h0) ? DAP_ZERO : {1'b0, dap_q};
		dap_t  = TICKS_W'(dap_f) * TICKS_W'(tmr ? DAP_UNIT1[rate] : DAP_UNIT0[rate]);
		stp_f  = STEP_BASE - {1'b0, srt_q};
		stp_t  = TICKS_W'(stp_f) * TICKS_W'(STEP_UNIT[rate]);

		ph_d     = ph_q;
		sk_d     = sk_q;
		cmd_d    = cmd_q;
		ccnt_d   = ccnt_q;
		res_d    = res_q;
		rcnt_d   = rcnt_q;
		ridx_d   = ridx_q;
		sense_d  = sense_q;
		cfg_d    = cfg_q;
		pres_d   = pres_q;
		st0_d    = st0_q;
		sk_drv_d = sk_drv_q;
		sk_hd_d  = sk_hd_q;
		tgt_d    = tgt_q;
		busy_d   = busy_q;
		dir_d    = dir_q;
		srt_d    = srt_q;
		dap_d    = dap_q;
		dbp_d    = dbp_q;
		dma_d    = dma_q;
		seek_go  = 1'b0;
		seek_end = 1'b0;
		abn      = 1'b0;
		issue    = 1'b0;
		clr_int  = 1'b0;
		set_int  = 1'b0;
		res_go   = 1'b0;
		res_sense = 1'b0;
		res_n    = 2'h1;
		res_v    = '0;
		t1.load  = 1'b0;
		t1.ticks = '0;
		t2.load  = 1'b0;
		t2.ticks = '0;

		if (wr_acc && paddr == CFG_OFS) begin
			cfg_d = pwdata[5:0];
		end

		if (take) begin
			cmd_d  = nc;
			ccnt_d = ccnt_q + 2'h1;
		end

		if (fin) begin
			ccnt_d = 2'h0;
			res_go = 1'b1;
			res_v[0] = INVALID_BYTE;
			if (!bad) begin
				unique case (op)
					OP_SEEK: begin
						res_go  = 1'b0;
						seek_go = (sk_q == SK_IDLE);
						if (seek_go) begin
							tgt_d    = wide ? {nc[3][7:4], nc[2]} : {4'h0, nc[2]};
							sk_drv_d = drv;
							sk_hd_d  = hd;
							busy_d[drv] = 1'b1;
						end
					end
					OP_DSTAT: begin
						res_v[0] = {1'b0, write_protect_input, 1'b0, track_zero_input,
							1'b0, hd, drv};
					end
					OP_SENSE: begin
						if (int_q) begin
							res_v     = {sptr[11:8], 4'h0, sptr[7:0], st0_q};
							res_n     = wide ? 2'h3 : 2'h2;
							res_sense = 1'b1;
						end
					end
					OP_TRK_RD, OP_TRK_WR: begin
						if (op[6]) begin
							if (hd) begin
								pres_d[drv][11:8] = nc[2][3:0];
							end else begin
								pres_d[drv][7:0] = nc[2];
							end
						end
						res_v[0] = hd ? {4'h0, pres_d[drv][11:8]} : pres_d[drv][7:0];
					end
					OP_SPEC: begin
						res_go = 1'b0;
						srt_d  = nc[1][7:4];
						dap_d  = nc[1][3:0];
						dbp_d  = nc[2][7:1];
						dma_d  = nc[2][0];
					end
					default: begin
						res_v[0] = INVALID_BYTE;
					end
				endcase
			end
		end

		if (res_go) begin
			ph_d    = PH_RES;
			res_d   = res_v;
			rcnt_d  = res_n;
			ridx_d  = 2'h0;
			sense_d = res_sense;
		end

		if (pop) begin
			ridx_d = ridx_q + 2'h1;
			if (ridx_q + 2'h1 == rcnt_q) begin
				ph_d = PH_CMD;
			end
			clr_int = sense_q && (ridx_q == 2'h0);
		end

		unique case (sk_q)
			SK_IDLE: begin
				if (seek_go) begin
					t1.load  = 1'b1;
					t1.ticks = dbp_t;
					sk_d     = SK_DELAY;
				end
			end
			SK_DELAY: begin
				if (t1.done) begin
					sk_d = SK_STEP;
				end
			end
			SK_STEP: begin
				if (cur == tgt_q) begin
					seek_end = 1'b1;
				end else if (!up && track_zero_input) begin
					seek_end = 1'b1;
					abn      = 1'b1;
					pres_d[sk_drv_q] = '0;
				end else begin
					issue = 1'b1;
					dir_d = up;
					pres_d[sk_drv_q] = up ? cur + 12'h001 : cur - 12'h001;
					t1.load  = 1'b1;
					t1.ticks = stp_t;
					sk_d     = SK_WAIT;
				end
				if (seek_end) begin
					sk_d    = SK_IDLE;
					busy_d[sk_drv_q] = 1'b0;
					set_int = 1'b1;
					st0_d   = {abn ? IC_ABNORMAL : IC_NORMAL, 1'b1, 2'b00, sk_hd_q,
						sk_drv_q};
					t2.load  = 1'b1;
					t2.ticks = dap_t;
				end
			end
			SK_WAIT: begin
				if (t1.done) begin
					sk_d = SK_STEP;
				end
			end
		endcase

		if (ready_change && !set_int) begin
			st0_d = {IC_READY, 6'h00};
		end
		int_d = int_q;
		if (clr_int) begin
			int_d = 1'b0;
		end
		if (set_int || ready_change) begin
			int_d = 1'b1;
		end

		step_d = issue || (step_q && pw_q != '0);
		pw_d   = issue ? PWW'(STEP_PULSE_CYC - 1) : (pw_q != '0 ? pw_q - 1'b1 : pw_q);

		prdata_d = prdata_q;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				MSR_OFS:  prdata_d = {24'h0, 1'b1, ph_q == PH_RES, 1'b0,
					ph_q == PH_RES || ccnt_q != 2'h0, busy_q};
				DATA_OFS: prdata_d = (ph_q == PH_RES) ? {24'h0, res_q[ridx_q]} : 32'h0;
				CFG_OFS:  prdata_d = {26'h0, cfg_q};
				TIME_OFS: prdata_d = {16'h0, srt_q, dap_q, dbp_q, dma_q};
				default:  prdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ph_q     <= PH_CMD;
			sk_q     <= SK_IDLE;
			cmd_q    <= '0;
			ccnt_q   <= 2'h0;
			res_q    <= '0;
			rcnt_q   <= 2'h0;
			ridx_q   <= 2'h0;
			sense_q  <= 1'b0;
			cfg_q    <= CFG_RESET;
			pres_q   <= '0;
			int_q    <= 1'b0;
			st0_q    <= 8'h00;
			sk_drv_q <= 2'h0;
			sk_hd_q  <= 1'b0;
			tgt_q    <= 12'h000;
			busy_q   <= 4'h0;
			step_q   <= 1'b0;
			dir_q    <= 1'b0;
			pw_q     <= '0;
			prdata_q <= 32'h0;
		end else begin
			ph_q     <= ph_d;
			sk_q     <= sk_d;
			cmd_q    <= cmd_d;
			ccnt_q   <= ccnt_d;
			res_q    <= res_d;
			rcnt_q   <= rcnt_d;
			ridx_q   <= ridx_d;
			sense_q  <= sense_d;
			cfg_q    <= cfg_d;
			pres_q   <= pres_d;
			int_q    <= int_d;
			st0_q    <= st0_d;
			sk_drv_q <= sk_drv_d;
			sk_hd_q  <= sk_hd_d;
			tgt_q    <= tgt_d;
			busy_q   <= busy_d;
			step_q   <= step_d;
			dir_q    <= dir_d;
			pw_q     <= pw_d;
			prdata_q <= prdata_d;
		end
	end

	// timing setup values are kept through reset
	always_ff @(posedge sys_clk) begin
		srt_q <= srt_d;
		dap_q <= dap_d;
		dbp_q <= dbp_d;
		dma_q <= dma_d;
	end

	assign prdata       = prdata_q;
	assign pready       = 1'b1;
	assign pslverr      = psel && penable && !(paddr inside {MSR_OFS, DATA_OFS, CFG_OFS, TIME_OFS});
	assign step_out     = step_q;
	assign dir_out      = dir_q;
	assign irq_out      = int_q;
	assign motor_hold   = t2.busy;
	assign non_dma_mode = dma_q;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_seek_cmd;
		fin && op == OP_SEEK && ok && sk_q == SK_IDLE;
	endsequence
	sequence s_issue;
		sk_q == SK_STEP && issue;
	endsequence
	sequence s_end_ok;
		sk_q == SK_STEP && seek_end && !abn;
	endsequence

	property p_seek_start;
		s_seek_cmd |=> sk_q == SK_DELAY && busy_q[sk_drv_q] && ph_q == PH_CMD;
	endproperty
	a_seek_start: assert property (p_seek_start) else $error("seek start wrong");
	property p_busy_hold;
		sk_q != SK_IDLE |-> busy_q[sk_drv_q];
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy lost in seek");
	property p_step_dir;
		s_issue |=> step_q && dir_q == $past(up) && sk_q == SK_WAIT;
	endproperty
	a_step_dir: assert property (p_step_dir) else $error("step direction wrong");
	property p_step_src;
		$rose(step_q) |-> $past(sk_q) == SK_STEP;
	endproperty
	a_step_src: assert property (p_step_src) else $error("step outside stepping");
	property p_seek_int;
		s_end_ok |=> int_q && st0_q[7:5] == 3'b001 && sk_q == SK_IDLE;
	endproperty
	a_seek_int: assert property (p_seek_int) else $error("seek end status wrong");
	property p_seek_abn;
		sk_q == SK_STEP && seek_end && abn |=> st0_q[7:5] == 3'b011;
	endproperty
	a_seek_abn: assert property (p_seek_abn) else $error("abnormal code wrong");
	property p_sense_bad;
		fin && op == OP_SENSE && !int_q |=>
			ph_q == PH_RES && res_q[0] == INVALID_BYTE && rcnt_q == 2'h1;
	endproperty
	a_sense_bad: assert property (p_sense_bad) else $error("sense not refused");
	property p_int_clr;
		pop && sense_q && ridx_q == 2'h0 && !set_int && !ready_change |=> !int_q;
	endproperty
	a_int_clr: assert property (p_int_clr) else $error("pending not cleared");
	property p_dstat;
		fin && op == OP_DSTAT && ok && !set_int && !ready_change |=>
			rcnt_q == 2'h1 && res_q[0][2:0] == {$past(hd), $past(drv)} && $stable(int_q);
	endproperty
	a_dstat: assert property (p_dstat) else $error("drive status wrong");
	property p_trk_wr;
		fin && op == OP_TRK_WR && ok && !hd && sk_q == SK_IDLE |=>
			pres_q[$past(drv)][7:0] == $past(last_b) && res_q[0] == $past(last_b);
	endproperty
	a_trk_wr: assert property (p_trk_wr) else $error("track write wrong");
	property p_trk_one;
		fin && (op == OP_TRK_RD || op == OP_TRK_WR) |=> ph_q == PH_RES && rcnt_q == 2'h1;
	endproperty
	a_trk_one: assert property (p_trk_one) else $error("track result count");
	property p_drv_map;
		fin && (op == OP_TRK_RD || op == OP_TRK_WR) && drv == 2'b11 && !cfg_q[CFG_FOUR] |=>
			res_q[0] == INVALID_BYTE;
	endproperty
	a_drv_map: assert property (p_drv_map) else $error("drive code 11 accepted");
	property p_spec;
		fin && op == OP_SPEC |=> {dbp_q, dma_q} == $past(last_b) && ph_q == PH_CMD;
	endproperty
	a_spec: assert property (p_spec) else $error("timing setup not loaded");
endmodule : fdc_seek_cmds

// >>> include/fdc_cmd_pkg.sv
// constants and types for the seek, status, track and timing command block
package fdc_cmd_pkg;
	localparam int CLK_NS         = 5;
	localparam int MS_NS          = 1000000;
	localparam int TICKS_PER_MS   = 6;
	localparam int TICK_CYC       = (MS_NS + TICKS_PER_MS * CLK_NS - 1) / (TICKS_PER_MS * CLK_NS);
	localparam int STEP_PULSE_NS  = 1000;
	localparam int STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TICKS_W        = 17;

	localparam logic [7:0] MSR_OFS  = 8'h00;
	localparam logic [7:0] DATA_OFS = 8'h04;
	localparam logic [7:0] CFG_OFS  = 8'h08;
	localparam logic [7:0] TIME_OFS = 8'h0C;

	localparam logic [7:0] OP_SEEK   = 8'h0F;
	localparam logic [7:0] OP_DSTAT  = 8'h04;
	localparam logic [7:0] OP_SENSE  = 8'h08;
	localparam logic [7:0] OP_TRK_RD = 8'h21;
	localparam logic [7:0] OP_TRK_WR = 8'h61;
	localparam logic [7:0] OP_SPEC   = 8'h03;
	localparam logic [7:0] INVALID_BYTE = 8'h80;

	localparam logic [1:0] IC_NORMAL   = 2'h0;
	localparam logic [1:0] IC_ABNORMAL = 2'h1;
	localparam logic [1:0] IC_READY    = 2'h3;

	localparam logic [4:0] STEP_BASE = 5'h10;
	localparam logic [4:0] DAP_ZERO  = 5'h10;
	localparam logic [7:0] DBP_ZERO  = 8'h80;

	localparam logic [5:0] CFG_RESET = 6'h00;
	localparam int CFG_WIDE = 0;
	localparam int CFG_TMR  = 1;
	localparam int CFG_RATE = 2;
	localparam int CFG_FOUR = 4;
	localparam int CFG_SWAP = 5;

	// per data rate 0:500K 1:300K 2:250K 3:1M, in sixths of a millisecond
	localparam logic [3:0][3:0]  STEP_UNIT = {4'h3, 4'hC, 4'hA, 4'h6};
	localparam logic [3:0][8:0]  DBP_UNIT0 = {9'h006, 9'h018, 9'h014, 9'h006};
	localparam logic [3:0][8:0]  DBP_UNIT1 = {9'h0C0, 9'h180, 9'h140, 9'h0C0};
	localparam logic [3:0][12:0] DAP_UNIT0 = {13'h0030, 13'h00C0, 13'h00A0, 13'h0060};
	localparam logic [3:0][12:0] DAP_UNIT1 = {13'h0C00, 13'h1800, 13'h1400, 13'h0C00};

	typedef enum logic [1:0] {PH_CMD = 2'b00, PH_RES = 2'b01} phase_t;
	typedef enum logic [1:0] {
		SK_IDLE  = 2'b00,
		SK_DELAY = 2'b01,
		SK_STEP  = 2'b11,
		SK_WAIT  = 2'b10
	} seek_t;
endpackage : fdc_cmd_pkg

// >>> include/tmr_if.sv
// load and completion signals between the command block and a delay timer
`timescale 1ns/1ps
interface tmr_if;
	import fdc_cmd_pkg::*;
	logic               load;
	logic [TICKS_W-1:0] ticks;
	logic               tick;
	logic               done;
	logic               busy;
	modport ctrl  (output load, ticks, input tick, done, busy);
	modport timer (input load, ticks, output tick, done, busy);
endinterface : tmr_if

// >>> rtl/tick_timer.sv
// down counter of sixth-millisecond ticks for step and motor delays
`timescale 1ns/1ps
module tick_timer
	import fdc_cmd_pkg::*;
#(
	parameter int tick_cyc = TICK_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	tmr_if.timer     t
);
	localparam int PW = $clog2(tick_cyc);

	logic [PW-1:0]      pre_q, pre_d;
	logic [TICKS_W-1:0] cnt_q, cnt_d;
	logic               run_q, run_d;

	if (tick_cyc < 2) begin : g_chk
		$error("tick_timer: tick_cyc below 2");
	end

	always_comb begin
		pre_d  = pre_q;
		cnt_d  = cnt_q;
		run_d  = run_q;
		t.tick = 1'b0;
		t.done = 1'b0;
		if (t.load) begin
			pre_d = '0;
			cnt_d = t.ticks;
			run_d = (t.ticks != '0);
		end else if (run_q) begin
			if (pre_q == PW'(tick_cyc - 1)) begin
				pre_d  = '0;
				t.tick = 1'b1;
				cnt_d  = cnt_q - 1'b1;
				if (cnt_q == TICKS_W'(1)) begin
					run_d  = 1'b0;
					t.done = 1'b1;
				end
			end else begin
				pre_d = pre_q + 1'b1;
			end
		end
	end

	assign t.busy = run_q;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_q <= '0;
			cnt_q <= '0;
			run_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			run_q <= run_d;
		end
	end

	property p_done_last;
		@(posedge sys_clk) disable iff (!rst_b)
		t.done |-> run_q && cnt_q == TICKS_W'(1) && pre_q == PW'(tick_cyc - 1);
	endproperty
	a_done_last: assert property (p_done_last) else $error("timer done off its last tick");
endmodule : tick_timer

// >>> test/drive_model.sv
// drive model: head position, track zero sensor and step timing
`timescale 1ns/1ps
module drive_model #(
	parameter int start_pos = 10
) (
	input  wire logic sys_clk,
	input  wire logic step_out,
	input  wire logic dir_out,
	output logic      track_zero_input,
	output logic      last_dir,
	output int        pos,
	output int        period,
	output int        since
);
	logic prev_q = 1'b0;
	initial begin
		pos = start_pos;
		since = 0;
		period = 0;
		last_dir = 1'b0;
	end
	// head stays where it is over a controller reset
	assign track_zero_input = (pos == 0);
	always @(posedge sys_clk) begin
		prev_q <= step_out;
		since <= since + 1;
		if (step_out && !prev_q) begin
			since <= 0;
			period <= since;
			last_dir <= dir_out;
			pos <= dir_out ? pos + 1 : (pos > 0 ? pos - 1 : 0);
		end
	end
endmodule : drive_model

// >>> test/fdc_seek_cmds_test.sv
// self-checking bench for the seek, status, track and timing commands
`timescale 1ns/1ps
module fdc_seek_cmds_test;
	import fdc_cmd_pkg::*;
	localparam int TC = 100;
	localparam int IV = 3 * TC;
	localparam int HI = IV + STEP_PULSE_CYC + 4;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        write_protect_input = 1'b0;
	logic        ready_change = 1'b0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, step_out, dir_out, track_zero_input;
	logic        irq_out, motor_hold, non_dma_mode, last_dir, err;
	int          pos, period, since;
	int          bad_count = 0;
	int          tests_run = 0;

	always #2.5 sys_clk = ~sys_clk;

	fdc_seek_cmds #(.tick_cyc(TC)) i_fdc_seek_cmds (
		.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .step_out(step_out), .dir_out(dir_out),
		.track_zero_input(track_zero_input), .write_protect_input(write_protect_input),
		.ready_change(ready_change), .irq_out(irq_out), .motor_hold(motor_hold),
		.non_dma_mode(non_dma_mode)
	);
	drive_model i_drive_model (
		.sys_clk(sys_clk), .step_out(step_out), .dir_out(dir_out),
		.track_zero_input(track_zero_input), .last_dir(last_dir), .pos(pos),
		.period(period), .since(since)
	);

	task summarize;
		if (bad_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge sys_clk);
	endtask : apb

	task wr(input logic [7:0] b);
		apb(1'b1, DATA_OFS, {24'h0, b});
	endtask : wr

	task res(input string n, input logic [7:0] e);
		apb(1'b0, DATA_OFS, 32'h0);
		chk(n, {24'h0, e}, rd);
	endtask : res

	task trk(input logic [7:0] op, input logic [7:0] sel, input logic [7:0] b, input logic [7:0] e);
		wr(op);
		wr(sel);
		wr(b);
		res("track_result", e);
		chk("track_irq", 32'h0, irq_out);
	endtask : trk

	task seek_run(input logic [7:0] t, input logic [7:0] nib, input bit wide,
		input int pos_e, input logic dir_e, input logic [7:0] st0);
		int n;
		wr(OP_SEEK);
		wr(8'h00);
		wr(t);
		if (wide) wr(nib);
		apb(1'b0, MSR_OFS, 32'h0);
		chk("busy", 32'h1, rd[0]);
		n = 0;
		while (irq_out !== 1'b1 && n < 20000) begin
			@(posedge sys_clk);
			n++;
		end
		chk("irq", 32'h1, irq_out);
		if (!st0[6]) chk("irq_gap", 32'h1, since >= IV - 2 && since <= HI);
		if (pos_e > 1) chk("period", 32'h1, period >= IV - 2 && period <= HI);
		chk("pos", pos_e, pos);
		chk("dir", dir_e, last_dir);
		apb(1'b0, MSR_OFS, 32'h0);
		chk("idle", 32'h0, rd[3:0]);
		chk("motor", 32'h1, motor_hold);
		chk("irq_hold", 32'h1, irq_out);
		wr(OP_SENSE);
		res("st0", st0);
		#1;
		chk("irq_clr", 32'h0, irq_out);
		res("ptr", t);
		if (wide) res("nibble", nib);
	endtask : seek_run

	task t_setup;
		wr(OP_SPEC);
		wr(8'hF1);
		wr(8'h03);
		chk("non_dma", 32'h1, non_dma_mode);
		apb(1'b1, TIME_OFS, 32'h0);
		apb(1'b0, TIME_OFS, 32'h0);
		chk("timing", 32'hF103, rd[15:0]);
		chk("spec_irq", 32'h0, irq_out);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h1, err);
		apb(1'b0, MSR_OFS, 32'h0);
		chk("msr", 32'h80, rd[7:0]);
		apb(1'b1, CFG_OFS, 32'h0C);
		wr(OP_SENSE);
		res("none_pending", INVALID_BYTE);
		wr(8'h12);
		res("bad_op", INVALID_BYTE);
	endtask : t_setup

	task t_track;
		trk(OP_TRK_WR, 8'h03, 8'h11, INVALID_BYTE);
		apb(1'b1, CFG_OFS, 32'h2C);
		trk(OP_TRK_WR, 8'h02, 8'h2A, 8'h2A);
		trk(OP_TRK_RD, 8'h02, 8'h00, 8'h2A);
		trk(OP_TRK_RD, 8'h01, 8'h55, 8'h00);
		@(posedge sys_clk);
		write_protect_input <= 1'b1;
		wr(OP_DSTAT);
		wr(8'h05);
		res("drive_status", 8'h45);
		chk("dstat_irq", 32'h0, irq_out);
	endtask : t_track

	task t_seeks;
		seek_run(8'h03, 8'h00, 1'b0, 13, 1'b1, 8'h20);
		trk(OP_TRK_WR, 8'h00, 8'h14, 8'h14);
		seek_run(8'h00, 8'h00, 1'b0, 0, 1'b0, 8'h60);
		@(posedge sys_clk);
		write_protect_input <= 1'b0;
		wr(OP_DSTAT);
		wr(8'h00);
		res("at_zero", 8'h10);
		apb(1'b1, CFG_OFS, 32'h1D);
		trk(OP_TRK_WR, 8'h04, 8'h01, 8'h01);
		trk(OP_TRK_WR, 8'h00, 8'h05, 8'h05);
		trk(OP_TRK_RD, 8'h04, 8'h00, 8'h01);
		seek_run(8'h07, 8'h10, 1'b1, 2, 1'b1, 8'h20);
	endtask : t_seeks

	task t_reset;
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		apb(1'b0, TIME_OFS, 32'h0);
		chk("kept_timing", 32'hF103, rd[15:0]);
		chk("kept_mode", 32'h1, non_dma_mode);
		@(posedge sys_clk);
		ready_change <= 1'b1;
		@(posedge sys_clk);
		ready_change <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("ready_irq", 32'h1, irq_out);
		wr(OP_SENSE);
		res("ready_st0", 8'hC0);
		#1;
		chk("ready_clr", 32'h0, irq_out);
		res("ready_ptr", 8'h00);
		wr(OP_SENSE);
		res("cleared", INVALID_BYTE);
	endtask : t_reset

	initial begin
		#200000;
		bad_count++;
		summarize();
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_setup();
		t_track();
		t_seeks();
		t_reset();
		summarize();
	end
endmodule : fdc_seek_cmds_test
